// ---- rtl/burst_write_lane_mask_defs.svh ----
// Timing and layout constants for the burst write lane mask block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef BURST_WRITE_LANE_MASK_DEFS_SVH
`define BURST_WRITE_LANE_MASK_DEFS_SVH

// Number of words carried by one write burst.
`define BWL_BURST_LEN 4
// Width of the beat index inside a burst.
`define BWL_BEAT_W 2
// Width of a nibble lane in the 8-bit organisation.
`define BWL_NIBBLE_W 4
// Width of a byte lane in the 9-, 18- and 36-bit organisations.
`define BWL_BYTE_W 9
// Default data width of the write port.
`define BWL_DEFAULT_DATA_W 36
// Default word address width of the array.
`define BWL_DEFAULT_ADDR_W 8

`endif

// ---- rtl/burst_write_lane_mask_pkg.sv ----
// Types shared by the burst write lane mask design.
// Assumes nothing of its surroundings.
package burst_write_lane_mask_pkg;

  // Progress of one write burst through its four data beats.
  typedef enum logic [2:0] {
    BURST_IDLE,
    BURST_WAIT_BEAT0,
    BURST_WAIT_BEAT1,
    BURST_WAIT_BEAT2,
    BURST_WAIT_BEAT3
  } burst_state_e;

endpackage

// ---- rtl/lane_mem.sv ----
// Word array with a separate write enable for each lane of a word.
// Assumes one clock; the array itself has no reset, as in the device.
`timescale 1ns/1ps

module lane_mem #(
  parameter int LANES = 4,
  parameter int LANE_W = 9,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LANES*LANE_W-1:0] wr_data,
  input wire logic [LANES-1:0] wr_lane_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [LANES*LANE_W-1:0] rd_data
);

  // Only a non-empty lane layout can be stored.
  if (LANES < 1 || LANE_W < 1 || ADDR_W < 1) begin : g_bad_shape
    $error("LANES, LANE_W and ADDR_W must all be at least 1.");
  end

  // Each lane keeps its own array, so no two processes ever write the same storage.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // Storage for this lane of every word.
    logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

    // The lane is written only while its own enable is set; otherwise it keeps its contents.
    always_ff @(posedge clk) begin
      if (wr_en && wr_lane_en[g]) begin
        mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
      end
    end

    // Registered read of this lane, cleared at reset so the output is defined from the start.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rd_data[g*LANE_W +: LANE_W] <= '0;
      end else begin
        rd_data[g*LANE_W +: LANE_W] <= mem[rd_addr];
      end
    end
  end

endmodule

// ---- rtl/burst_write_lane_mask.sv ----
// Write port of a four-word burst memory with per-lane write masking.
// Assumes K and K_N are slow pin clocks, sampled on CLOCK, each level lasting several CLOCK cycles,
// and that address, data and selects are steady around the K and K_N rises.
//
// Overview of operation
// [RULE1] 8-bit: nibble selects gate bits 3:0, 7:4.
// [RULE2] 18-bit: selects gate bits 8:0 and 17:9.
// [RULE3] 9-bit: one select gates all nine bits.
// [RULE4] 36-bit: four selects gate four 9-bit lanes.
// [RULE5] All selects high: word untouched, burst continues.
// [RULE6] Selects sampled per beat, applied only there.
// [RULE7] Four beats on K, K_N rises of t+1, t+2.
// [RULE8] Write start on consecutive K rises: second ignored.
// [RULE9] Each beat masks only its own burst word.
`timescale 1ns/1ps
`include "burst_write_lane_mask_defs.svh"

module burst_write_lane_mask #(
  parameter int DATA_W = `BWL_DEFAULT_DATA_W,
  parameter int ADDR_W = `BWL_DEFAULT_ADDR_W,
  localparam int LANE_W = (DATA_W == 8) ? `BWL_NIBBLE_W : `BWL_BYTE_W,
  localparam int LANES = DATA_W / LANE_W
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic K,
  input wire logic K_N,
  input wire logic WRITE_PORT_SELECT_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] D,
  input wire logic [LANES-1:0] LANE_WRITE_SELECT_N,
  input wire logic [ADDR_W-1:0] READ_ADDR,
  output logic [DATA_W-1:0] READ_DATA,
  output logic WRITE_BUSY
);

  // Only the four documented organisations are served.
  if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_width
    $error("DATA_W must be 8, 9, 18 or 36.");
  end
  if (ADDR_W < `BWL_BEAT_W) begin : g_bad_addr
    $error("ADDR_W too small for a burst.");
  end

  // Width of the bundle of pins that cross into the CLOCK domain.
  localparam int PIN_W = 3 + ADDR_W + DATA_W + LANES;

  // Raw pins gathered into one vector.
  logic [PIN_W-1:0] pins;
  // Three synchroniser stages.
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  // Filtered pin levels, updated only where stages two and three agree.
  logic [PIN_W-1:0] stable;
  // Filtered level of K and K_N on the previous cycle.
  logic k_prev;
  logic kn_prev;
  // Filtered views of each pin.
  logic k_lvl;
  logic kn_lvl;
  logic sel_n_lvl;
  logic [ADDR_W-1:0] addr_lvl;
  logic [DATA_W-1:0] data_lvl;
  logic [LANES-1:0] lane_sel_n_lvl;
  // One-cycle pulses on filtered rising edges.
  logic k_rise;
  logic kn_rise;
  // Burst sequencing.
  burst_write_lane_mask_pkg::burst_state_e state;
  logic started_last;
  logic start;
  logic pend_valid;
  logic [ADDR_W-1:0] pend_addr;
  logic [ADDR_W-1:0] burst_addr;
  // Beat write toward the array.
  logic beat_take;
  logic [`BWL_BEAT_W-1:0] beat_idx;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [LANES-1:0] wr_lane_en;

  assign pins = {K, K_N, WRITE_PORT_SELECT_N, ADDR, D, LANE_WRITE_SELECT_N};

  // Three-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A pin change counts once stages two and three agree on it.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      stable <= '0;
    end else begin
      stable <= (sync2 & ~(sync2 ^ sync3)) | (stable & (sync2 ^ sync3));
    end
  end

  assign {k_lvl, kn_lvl, sel_n_lvl, addr_lvl, data_lvl, lane_sel_n_lvl} = stable;

  // Previous filtered clock levels for edge detection.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      k_prev <= 1'b0;
      kn_prev <= 1'b0;
    end else begin
      k_prev <= k_lvl;
      kn_prev <= kn_lvl;
    end
  end

  assign k_rise = k_lvl && !k_prev;
  assign kn_rise = kn_lvl && !kn_prev;

  // A start on the K rise right after an accepted start is dropped.
  assign start = k_rise && !sel_n_lvl && !started_last; // [RULE8]

  // Remembers whether the last K rise started a write.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      started_last <= 1'b0;
    end else if (k_rise) begin
      started_last <= start; // [RULE8]
    end
  end

  // Beat taken on this cycle, from the edge the current state waits for.
  always_comb begin
    beat_take = 1'b0;
    beat_idx = 2'h0;
    unique case (state)
      burst_write_lane_mask_pkg::BURST_IDLE: begin
        beat_take = 1'b0;
      end
      burst_write_lane_mask_pkg::BURST_WAIT_BEAT0: begin
        beat_take = k_rise; // [RULE7]
        beat_idx = 2'h0;
      end
      burst_write_lane_mask_pkg::BURST_WAIT_BEAT1: begin
        beat_take = kn_rise; // [RULE7]
        beat_idx = 2'h1;
      end
      burst_write_lane_mask_pkg::BURST_WAIT_BEAT2: begin
        beat_take = k_rise; // [RULE7]
        beat_idx = 2'h2;
      end
      burst_write_lane_mask_pkg::BURST_WAIT_BEAT3: begin
        beat_take = kn_rise; // [RULE7]
        beat_idx = 2'h3;
      end
    endcase
  end

  // An accepted start waits here until the K_N rise of its own cycle t.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pend_valid <= 1'b0;
      pend_addr <= '0;
    end else if (start) begin
      pend_valid <= 1'b1;
      pend_addr <= addr_lvl;
    end else if (kn_rise && (state == burst_write_lane_mask_pkg::BURST_IDLE ||
                             state == burst_write_lane_mask_pkg::BURST_WAIT_BEAT3)) begin
      pend_valid <= 1'b0;
    end
  end

  // Burst sequencer: a pending start becomes the active burst at a K_N rise.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= burst_write_lane_mask_pkg::BURST_IDLE;
      burst_addr <= '0;
    end else begin
      unique case (state)
        burst_write_lane_mask_pkg::BURST_IDLE,
        burst_write_lane_mask_pkg::BURST_WAIT_BEAT3: begin
          if (kn_rise) begin
            if (pend_valid) begin
              state <= burst_write_lane_mask_pkg::BURST_WAIT_BEAT0; // [RULE7]
              burst_addr <= pend_addr;
            end else begin
              state <= burst_write_lane_mask_pkg::BURST_IDLE;
            end
          end
        end
        burst_write_lane_mask_pkg::BURST_WAIT_BEAT0: begin
          if (k_rise) begin
            state <= burst_write_lane_mask_pkg::BURST_WAIT_BEAT1;
          end
        end
        burst_write_lane_mask_pkg::BURST_WAIT_BEAT1: begin
          if (kn_rise) begin
            state <= burst_write_lane_mask_pkg::BURST_WAIT_BEAT2;
          end
        end
        burst_write_lane_mask_pkg::BURST_WAIT_BEAT2: begin
          if (k_rise) begin
            state <= burst_write_lane_mask_pkg::BURST_WAIT_BEAT3;
          end
        end
      endcase
    end
  end

  // Beat register: data, its own word address and its own lane mask, sampled at this beat only.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_lane_en <= '0;
    end else begin
      wr_en <= beat_take;
      if (beat_take) begin
        wr_addr <= ADDR_W'(burst_addr + ADDR_W'(beat_idx)); // [RULE9]
        wr_data <= data_lvl;
        wr_lane_en <= ~lane_sel_n_lvl; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6]
      end
    end
  end

  // Busy while a burst is active or one is waiting to begin.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_BUSY <= 1'b0;
    end else begin
      WRITE_BUSY <= pend_valid || (state != burst_write_lane_mask_pkg::BURST_IDLE);
    end
  end

  // Lane-masked array; unselected lanes keep their contents.
  lane_mem #(
    .LANES(LANES),
    .LANE_W(LANE_W),
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clk(CLOCK),
    .rst_n(RST_N),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_lane_en(wr_lane_en), // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
    .rd_addr(READ_ADDR),
    .rd_data(READ_DATA)
  );

endmodule

// ---- verification/burst_write_lane_mask_props.sv ----
// Checker for the write port of the burst write lane mask block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module bwl_props #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 8
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic K,
  input wire logic K_N,
  input wire logic WRITE_PORT_SELECT_N,
  input wire logic [ADDR_W-1:0] READ_ADDR,
  input wire logic [DATA_W-1:0] READ_DATA,
  input wire logic WRITE_BUSY
);
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Cycles since a start request stood on the pins, saturating.
  logic [4:0] since_start;
  // Cycles the port has been idle, saturating.
  logic [2:0] idle_len;
  // Counts from the last start request.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) since_start <= 5'h1f;
    else if (K && !WRITE_PORT_SELECT_N) since_start <= 5'h00;
    else if (since_start != 5'h1f) since_start <= since_start + 5'h01;
  end
  // Counts idle cycles so that late array updates have landed.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) idle_len <= 3'h0;
    else if (WRITE_BUSY) idle_len <= 3'h0;
    else if (idle_len != 3'h7) idle_len <= idle_len + 3'h1;
  end
  AST_RISE_START: assert property ($rose(WRITE_BUSY) |-> since_start < 5'h07)
    else $error("busy rose with no start");
  AST_RISE_K: assert property ($rose(WRITE_BUSY) |-> K && !K_N)
    else $error("busy rose outside K high");
  AST_FALL_KN: assert property ($fell(WRITE_BUSY) |-> K_N && !K)
    else $error("busy fell outside K_N high");
  AST_LONG: assert property ($rose(WRITE_BUSY) |=> WRITE_BUSY [*8])
    else $error("burst ended too soon");
  AST_ENDS: assert property ($rose(WRITE_BUSY) |-> ##[1:120] !WRITE_BUSY)
    else $error("burst never ended");
  AST_QUIET: assert property (!WRITE_BUSY && since_start > 5'h08 |=> !WRITE_BUSY)
    else $error("busy with no start");
  AST_HELD: assert property (idle_len > 3'h3 && $stable(READ_ADDR) |=> $stable(READ_DATA))
    else $error("word changed while idle");
  AST_RESET: assert property ($rose(RST_N) |-> READ_DATA == '0 && !WRITE_BUSY)
    else $error("outputs not clear after reset");
endmodule
bind burst_write_lane_mask bwl_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_props (.CLOCK(CLOCK), .RST_N(RST_N),
  .K(K), .K_N(K_N), .WRITE_PORT_SELECT_N(WRITE_PORT_SELECT_N), .READ_ADDR(READ_ADDR), .READ_DATA(READ_DATA),
  .WRITE_BUSY(WRITE_BUSY));

// ---- verification/lane_ctrl_model.sv ----
// Model of the memory controller that drives the write port.
// Assumes the bench calls cycle once for each write clock period.
`timescale 1ns/1ps
module lane_ctrl_model (
  input wire logic clk,
  output logic k,
  output logic k_n,
  output logic sel_n,
  output logic [7:0] addr,
  output logic [35:0] d,
  output logic [3:0] lanes_n
);
  // Clocks low and selects inactive before the first frame.
  initial begin
    {k, k_n, sel_n, addr, d, lanes_n} = {2'b00, 1'b1, 8'h00, 36'h0, 4'hf};
  end
  // One half period: pins set two cycles before the rise, held seven after it.
  task automatic half(input logic rk, input logic s, input logic [7:0] a, input logic [35:0] v,
                      input logic [3:0] m);
    @(negedge clk);
    sel_n <= s;
    addr <= s ? ~addr : a; // Unused address lines do not keep the last value.
    d <= (&m) ? ~d : v;
    lanes_n <= m;
    repeat (2) @(negedge clk);
    k <= rk;
    k_n <= !rk;
    repeat (6) @(negedge clk);
  endtask
  // One write clock period: the K half with any request, then the K_N half.
  task automatic cycle(input logic s, input logic [7:0] a, input logic [35:0] v0, input logic [35:0] v1,
                       input logic [3:0] m0, input logic [3:0] m1);
    half(1'b1, s, a, v0, m0);
    half(1'b0, 1'b1, a, v1, m1);
  endtask
endmodule

// ---- verification/test_burst_write_lane_mask.sv ----
// Self-checking bench for the burst write lane mask block.
// Assumes the controller model drives every write pin.
`timescale 1ns/1ps
module test_burst_write_lane_mask;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] READ_ADDR = 8'h00;
  logic [35:0] READ_DATA;
  logic WRITE_BUSY, k, k_n, sel_n;
  logic [7:0] addr;
  logic [35:0] d;
  logic [3:0] lanes_n;
  logic [7:0] read_8; // Read data of the 8-bit organisation.
  logic [8:0] read_9; // Read data of the 9-bit organisation.
  logic [17:0] read_18; // Read data of the 18-bit organisation.
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [35:0] exp_mem [logic [7:0]]; // Expected word contents.
  logic [7:0] exp_nib [logic [7:0]]; // Expected words of the 8-bit organisation.
  always #2.5 CLOCK = ~CLOCK;
  burst_write_lane_mask #(.DATA_W(36), .ADDR_W(8)) dut (.CLOCK(CLOCK), .RST_N(RST_N), .K(k), .K_N(k_n),
    .WRITE_PORT_SELECT_N(sel_n), .ADDR(addr), .D(d), .LANE_WRITE_SELECT_N(lanes_n), .READ_ADDR(READ_ADDR),
    .READ_DATA(READ_DATA), .WRITE_BUSY(WRITE_BUSY));
  // Narrower organisations share the pins, each seeing the low data bits and the low selects.
  burst_write_lane_mask #(.DATA_W(8), .ADDR_W(8)) dut_8 (.CLOCK(CLOCK), .RST_N(RST_N), .K(k), .K_N(k_n),
    .WRITE_PORT_SELECT_N(sel_n), .ADDR(addr), .D(d[7:0]), .LANE_WRITE_SELECT_N(lanes_n[1:0]),
    .READ_ADDR(READ_ADDR), .READ_DATA(read_8), .WRITE_BUSY());
  burst_write_lane_mask #(.DATA_W(9), .ADDR_W(8)) dut_9 (.CLOCK(CLOCK), .RST_N(RST_N), .K(k), .K_N(k_n),
    .WRITE_PORT_SELECT_N(sel_n), .ADDR(addr), .D(d[8:0]), .LANE_WRITE_SELECT_N(lanes_n[0:0]),
    .READ_ADDR(READ_ADDR), .READ_DATA(read_9), .WRITE_BUSY());
  burst_write_lane_mask #(.DATA_W(18), .ADDR_W(8)) dut_18 (.CLOCK(CLOCK), .RST_N(RST_N), .K(k), .K_N(k_n),
    .WRITE_PORT_SELECT_N(sel_n), .ADDR(addr), .D(d[17:0]), .LANE_WRITE_SELECT_N(lanes_n[1:0]),
    .READ_ADDR(READ_ADDR), .READ_DATA(read_18), .WRITE_BUSY());
  lane_ctrl_model ctl (.clk(CLOCK), .k(k), .k_n(k_n), .sel_n(sel_n), .addr(addr), .d(d), .lanes_n(lanes_n));
  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Records one beat: only lanes with a low select change.
  task automatic note(input logic [7:0] a, input logic [35:0] v, input logic [3:0] m);
    for (int i = 0; i < 4; i++) if (!m[i]) exp_mem[a][9*i+:9] = v[9*i+:9];
    for (int i = 0; i < 2; i++) if (!m[i]) exp_nib[a][4*i+:4] = v[4*i+:4];
  endtask
  // Compares one value, counting the check and any mismatch.
  task automatic compare(input string what, input logic [7:0] a, input logic [35:0] exp, input logic [35:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s at %h expected %h seen %h", what, a, exp, seen);
    end
  endtask
  // Waits for idle, then reads back four words of every organisation.
  task automatic check_words(input logic [7:0] a[4]);
    for (int n = 0; n < 200 && WRITE_BUSY !== 1'b0; n++) @(negedge CLOCK);
    compare("busy", 8'h00, 36'h0, 36'(WRITE_BUSY));
    repeat (4) @(negedge CLOCK);
    foreach (a[i]) begin
      READ_ADDR = a[i];
      repeat (2) @(negedge CLOCK);
      compare("x36", a[i], exp_mem[a[i]], READ_DATA);
      compare("x18", a[i], 36'(exp_mem[a[i]][17:0]), 36'(read_18));
      compare("x9", a[i], 36'(exp_mem[a[i]][8:0]), 36'(read_9));
      compare("x8", a[i], 36'(exp_nib[a[i]]), 36'(read_8));
    end
  endtask
  // One burst at base a, each beat with its own lane selects.
  task automatic burst(input logic [7:0] a, input logic [35:0] v[4], input logic [3:0] m[4]);
    ctl.cycle(1'b0, a, 36'h0, 36'h0, 4'hf, 4'hf);
    ctl.cycle(1'b1, a, v[0], v[1], m[0], m[1]);
    ctl.cycle(1'b1, a, v[2], v[3], m[2], m[3]);
    for (int i = 0; i < 4; i++) note(a + 8'(i), v[i], m[i]);
  endtask
  // Fills words across the wrap, then writes one lane of each, then mixed masks.
  task automatic lane_masks();
    burst(8'hfe, '{4{36'hfffffffff}}, '{4{4'h0}});
    burst(8'hfe, '{4{36'h0}}, '{4'he, 4'hd, 4'hb, 4'h7});
    check_words('{8'hfe, 8'hff, 8'h00, 8'h01});
    burst(8'hfe, '{36'h123456789, 36'hfedcba987, 36'h0f0f0f0f0, 36'ha5a5a5a5a}, '{4'h0, 4'hf, 4'h5, 4'ha});
    check_words('{8'hfe, 8'hff, 8'h00, 8'h01});
  endtask
  // Start, a refused start on the next K rise, then a seamless start after it.
  task automatic close_starts();
    logic [35:0] v[8];
    foreach (v[i]) v[i] = 36'h111111111 * 36'(i + 1);
    burst(8'h40, '{4{36'h0}}, '{4{4'h0}});
    ctl.cycle(1'b0, 8'h10, 36'h0, 36'h0, 4'hf, 4'hf);
    ctl.cycle(1'b0, 8'h40, v[0], v[1], 4'h0, 4'h0);
    ctl.cycle(1'b0, 8'h20, v[2], v[3], 4'h0, 4'h0);
    ctl.cycle(1'b1, 8'h20, v[4], v[5], 4'h0, 4'h0);
    ctl.cycle(1'b1, 8'h20, v[6], v[7], 4'h0, 4'h0);
    for (int i = 0; i < 8; i++) note(8'(i % 4) + (i < 4 ? 8'h10 : 8'h20), v[i], 4'h0);
    check_words('{8'h10, 8'h13, 8'h20, 8'h23});
    check_words('{8'h40, 8'h41, 8'h42, 8'h43});
  endtask
  // Cuts a hang short.
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end
  // Reset, then the scenarios in turn.
  initial begin
    repeat (12) @(negedge CLOCK);
    RST_N = 1'b1;
    repeat (4) @(negedge CLOCK);
    lane_masks();
    close_starts();
    summarize();
  end
endmodule
